// File: inc/tsp_pkg.sv
/*
 Register map, field positions, reset values and status bits of the timed serdes I/O port.
 Assumes an AXI4-Lite master with 32-bit data; every register is one aligned word.
*/
package tsp_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DATA    = 8'h04;
   localparam logic [7:0] OFS_COND    = 8'h08;
   localparam logic [7:0] OFS_TIME    = 8'h0C;
   localparam logic [7:0] OFS_COUNT   = 8'h10;
   localparam logic [7:0] OFS_TSTAMP  = 8'h14;
   localparam logic [7:0] OFS_CLKDIV  = 8'h18;
   localparam logic [7:0] OFS_CLKSRC  = 8'h1C;
   localparam logic [7:0] OFS_IRQSTAT = 8'h20;
   localparam logic [7:0] OFS_IRQMASK = 8'h24;
   localparam logic [7:0] OFS_STATUS  = 8'h28;

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   localparam int CTRL_W        = 12;
   localparam int CB_EN         = 0;
   localparam int CB_DIR_OUT    = 1;
   localparam int CB_OPEN_COLL  = 2;
   localparam int CB_COND_EN    = 3;
   localparam int CB_COND_NEQ   = 4;
   localparam int CB_SERIAL     = 5;
   localparam int CB_SEL_LO     = 6;
   localparam int CB_SEL_HI     = 8;
   localparam int CB_STRB_IN    = 9;
   localparam int CB_STRB_OUT   = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

   // ------------------------------------------------------------
   // Clock blocks
   // ------------------------------------------------------------
   localparam int NUM_CB        = 6;
   localparam int DIV_W         = 6;
   localparam logic [29:0] CLKDIV_RST = 30'h0000_0000;
   localparam logic [4:0]  CLKSRC_RST = 5'h00;
   localparam real REF_CLK_MHZ  = 100.0;
   localparam real SYS_CLK_MHZ  = 25.0;

   // ------------------------------------------------------------
   // Interrupt bits, status bits, counter
   // ------------------------------------------------------------
   localparam int IB_XFER       = 0;
   localparam int IB_COND       = 1;
   localparam int IRQ_W         = 2;
   localparam int SB_RX_VALID   = 0;
   localparam int SB_TX_PEND    = 1;
   localparam int SB_SHIFTING   = 2;
   localparam int CNT_W         = 16;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: hdl/tsp_port.sv
/*
 Timed serdes I/O port: one port of WIDTH pins with transfer register, serdes,
 16-bit port counter, timestamp, conditional input, open-collector output,
 strobes, six clock blocks and an AXI4-Lite register slave.
 Assumes all inputs are synchronous to clk; pin wires are resolved outside
 from pin_out and pin_oe.
*/
// Contract
// (RULE1) Ports are 1, 4, 8, 16 or 32 bits
// (RULE2) All pins of a port share direction
// (RULE3) Drive pins, or sample with optional condition
// (RULE4) Each port access completes in one cycle
// (RULE5) Open collector: zero drives low, one floats
// (RULE6) Data passes serdes and transfer register; parallel mode (CB_SERIAL clear) bypasses the serdes
// (RULE7) 16-bit counter times the transfer
// (RULE8) Counter readable any time, delays operations
// (RULE9) Each transfer captures counter as timestamp
// (RULE10) Enabled link disables shared port pins
// (RULE11) Narrower enabled port overrides wider port pins
// (RULE12) Port always transfers at full width
// (RULE13) Six clock blocks, block 0 reference
// (RULE14) Clock block may use 1-bit port
// (RULE15) Inbound strobe qualifies, outbound strobe accompanies
// (RULE16) After reset port uses clock block 0
// (RULE17) Counter steps per clock tick, wraps
// (RULE18) Conditional input completion raises core event
module tsp_port #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0]      pin_out,
   output logic [WIDTH-1:0]      pin_oe,
   input  wire logic [WIDTH-1:0] pin_taken,
   input  wire logic             link_en,
   input  wire logic             ext_clk_in,
   input  wire logic             inbound_strobe,
   output logic                  outbound_strobe,
   output logic                  port_event,
   output logic                  irq
);
   localparam int CW = tsp_pkg::CTRL_W;
   localparam int DW = tsp_pkg::DIV_W;
   localparam int NB = tsp_pkg::NUM_CB;
   localparam int TW = tsp_pkg::CNT_W;
   localparam logic [5:0] WIDTH_BITS = 6'(WIDTH);

   typedef struct packed {
      logic [CW-1:0]                ctrl;
      logic [WIDTH-1:0]             cond_val;
      logic [TW-1:0]                time_val;
      logic                         time_armed;
      logic [29:0]                  clk_div;
      logic [4:0]                   clk_src;
      logic [NB-2:0][DW-1:0]        div_cnt;
      logic                         ext_prev;
      logic [tsp_pkg::IRQ_W-1:0]    irq_mask;
      logic [tsp_pkg::IRQ_W-1:0]    irq_stat;
      logic [WIDTH-1:0]             xfer_tx;
      logic                         tx_pend;
      logic [WIDTH-1:0]             xfer_rx;
      logic                         rx_valid;
      logic [WIDTH-1:0]             serdes;
      logic [5:0]                   bit_cnt;
      logic                         shifting;
      logic [WIDTH-1:0]             pin_val;
      logic [TW-1:0]                cnt;
      logic [TW-1:0]                tstamp;
      logic                         out_strobe;
      logic                         ev;
      logic                         aw_got;
      logic                         w_got;
      logic [7:0]                   awaddr;
      logic [31:0]                  wdata;
      logic [3:0]                   wstrb;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         rvalid;
      logic [31:0]                  rdata;
      logic [1:0]                   rresp;
   } tsp_state_t;

   tsp_state_t state_ff;
   tsp_state_t nxt_state;
   logic [NB-1:0]    cb_tick;
   logic             port_tick;
   logic [WIDTH-1:0] pin_mask;
   logic             time_ok;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic cond_met(input logic [WIDTH-1:0] v,
                                     input logic [CW-1:0]    c,
                                     input logic [WIDTH-1:0] ref_v);
      logic eq;
      eq = (v == ref_v);
      return !c[tsp_pkg::CB_COND_EN] || (c[tsp_pkg::CB_COND_NEQ] ? !eq : eq);
   endfunction

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   logic dir_out;
   logic open_coll;
   assign dir_out   = state_ff.ctrl[tsp_pkg::CB_EN] && state_ff.ctrl[tsp_pkg::CB_DIR_OUT];
   assign open_coll = state_ff.ctrl[tsp_pkg::CB_OPEN_COLL];
   assign pin_mask  = link_en ? '0 : ~pin_taken; // RULE10 RULE11
   assign pin_out   = open_coll ? '0 : state_ff.pin_val; // RULE5
   assign pin_oe    = dir_out ? (pin_mask & (open_coll ? ~state_ff.pin_val : '1)) : '0; // RULE2

   assign s_axi_awready   = !state_ff.aw_got && !state_ff.bvalid;
   assign s_axi_wready    = !state_ff.w_got && !state_ff.bvalid;
   assign s_axi_arready   = !state_ff.rvalid;
   assign s_axi_bvalid    = state_ff.bvalid;
   assign s_axi_bresp     = state_ff.bresp;
   assign s_axi_rvalid    = state_ff.rvalid;
   assign s_axi_rdata     = state_ff.rdata;
   assign s_axi_rresp     = state_ff.rresp;
   assign outbound_strobe = state_ff.out_strobe;
   assign port_event      = state_ff.ev;
   assign irq             = |(state_ff.irq_stat & state_ff.irq_mask);
   assign time_ok = !state_ff.time_armed || (state_ff.cnt == state_ff.time_val); // RULE7

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      tsp_state_t               q;
      logic [tsp_pkg::IRQ_W-1:0] ev_set;
      logic [WIDTH-1:0]         sampled;
      logic [WIDTH-1:0]         word;
      logic                     word_rdy;
      logic                     src_ev;
      logic [DW-1:0]            div_v;
      logic [2:0]               sel;
      logic [31:0]              rd;
      logic                     hit;
      q        = state_ff;
      nxt_state = state_ff;
      ev_set   = '0;
      sampled  = pin_in & pin_mask; // RULE12
      word     = sampled;
      word_rdy = 1'b0;
      rd       = '0;
      hit      = 1'b1;
      src_ev   = 1'b0;
      div_v    = '0;
      sel      = '0;
      nxt_state.out_strobe = 1'b0;
      nxt_state.ev         = 1'b0;
      nxt_state.ext_prev   = ext_clk_in;

      // Clock blocks: block 0 ticks every cycle, others divide clk or the pin
      cb_tick[0] = 1'b1; // RULE13
      for (int k = 1; k < NB; k++) begin
         src_ev = q.clk_src[k-1] ? (ext_clk_in && !q.ext_prev) : 1'b1; // RULE14
         div_v  = q.clk_div[(k-1)*DW +: DW];
         cb_tick[k] = 1'b0;
         if (src_ev) begin
            if (q.div_cnt[k-1] >= div_v) begin
               cb_tick[k] = 1'b1;
               nxt_state.div_cnt[k-1] = '0;
            end else begin
               nxt_state.div_cnt[k-1] = q.div_cnt[k-1] + 1'b1;
            end
         end
      end
      sel = q.ctrl[tsp_pkg::CB_SEL_HI:tsp_pkg::CB_SEL_LO];
      port_tick = (sel < 3'(NB)) ? cb_tick[sel] : 1'b0;

      // Read channel; reading DATA frees the transfer register
      if (s_axi_arvalid && !q.rvalid) begin // RULE4
         if (s_axi_araddr == tsp_pkg::OFS_CTRL) begin
            rd = 32'(q.ctrl);
         end else if (s_axi_araddr == tsp_pkg::OFS_DATA) begin
            rd = 32'(q.xfer_rx);
            nxt_state.rx_valid = 1'b0;
         end else if (s_axi_araddr == tsp_pkg::OFS_COND) begin
            rd = 32'(q.cond_val);
         end else if (s_axi_araddr == tsp_pkg::OFS_TIME) begin
            rd = 32'(q.time_val);
         end else if (s_axi_araddr == tsp_pkg::OFS_COUNT) begin
            rd = 32'(q.cnt); // RULE8
         end else if (s_axi_araddr == tsp_pkg::OFS_TSTAMP) begin
            rd = 32'(q.tstamp);
         end else if (s_axi_araddr == tsp_pkg::OFS_CLKDIV) begin
            rd = 32'(q.clk_div);
         end else if (s_axi_araddr == tsp_pkg::OFS_CLKSRC) begin
            rd = 32'(q.clk_src);
         end else if (s_axi_araddr == tsp_pkg::OFS_IRQSTAT) begin
            rd = 32'(q.irq_stat);
         end else if (s_axi_araddr == tsp_pkg::OFS_IRQMASK) begin
            rd = 32'(q.irq_mask);
         end else if (s_axi_araddr == tsp_pkg::OFS_STATUS) begin
            rd = 32'({q.shifting, q.tx_pend, q.rx_valid});
         end else begin
            hit = 1'b0;
         end
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = rd;
         nxt_state.rresp  = hit ? tsp_pkg::RESP_OKAY : tsp_pkg::RESP_SLVERR;
      end else if (q.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end

      // Port engine
      if (port_tick) begin
         nxt_state.cnt = q.cnt + 1'b1; // RULE17
      end
      if (q.ctrl[tsp_pkg::CB_EN] && port_tick) begin
         if (q.ctrl[tsp_pkg::CB_DIR_OUT]) begin
            if (q.shifting) begin
               nxt_state.pin_val    = {q.pin_val[WIDTH-1:1 % WIDTH], q.serdes[0]};
               nxt_state.serdes     = q.serdes >> 1; // RULE6
               nxt_state.bit_cnt    = q.bit_cnt - 1'b1;
               nxt_state.shifting   = (q.bit_cnt != 6'h01);
               nxt_state.out_strobe = q.ctrl[tsp_pkg::CB_STRB_OUT]; // RULE15
            end else if (q.tx_pend && time_ok) begin // RULE7
               if (q.ctrl[tsp_pkg::CB_SERIAL]) begin
                  nxt_state.serdes   = q.xfer_tx;
                  nxt_state.bit_cnt  = WIDTH_BITS;
                  nxt_state.shifting = 1'b1;
               end else begin
                  nxt_state.pin_val    = q.xfer_tx; // RULE3
                  nxt_state.out_strobe = q.ctrl[tsp_pkg::CB_STRB_OUT]; // RULE15
               end
               nxt_state.tx_pend    = 1'b0;
               nxt_state.tstamp     = q.cnt; // RULE9
               nxt_state.time_armed = 1'b0;
               ev_set[tsp_pkg::IB_XFER] = 1'b1;
            end
         end else if (!q.ctrl[tsp_pkg::CB_STRB_IN] || inbound_strobe) begin // RULE15
            if (q.ctrl[tsp_pkg::CB_SERIAL]) begin
               word = WIDTH'({sampled[0], q.serdes} >> 1); // RULE6
               nxt_state.serdes = word;
               if (q.bit_cnt == WIDTH_BITS - 6'h01) begin
                  nxt_state.bit_cnt = '0;
                  word_rdy = 1'b1;
               end else begin
                  nxt_state.bit_cnt = q.bit_cnt + 1'b1;
               end
            end else begin
               word_rdy = 1'b1;
            end
            if (word_rdy && time_ok && cond_met(word, q.ctrl, q.cond_val)) begin // RULE3
               nxt_state.xfer_rx    = word; // RULE1
               nxt_state.rx_valid   = 1'b1;
               nxt_state.tstamp     = q.cnt; // RULE9
               nxt_state.time_armed = 1'b0;
               ev_set[tsp_pkg::IB_XFER] = 1'b1;
               if (q.ctrl[tsp_pkg::CB_COND_EN]) begin
                  ev_set[tsp_pkg::IB_COND] = 1'b1;
                  nxt_state.ev = 1'b1; // RULE18
               end
            end
         end
      end

      // Write channel: both halves latched, then applied
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_state.aw_got = 1'b1;
         nxt_state.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_state.w_got = 1'b1;
         nxt_state.wdata = s_axi_wdata;
         nxt_state.wstrb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got) begin // RULE4
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got  = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp  = tsp_pkg::RESP_OKAY;
         if (q.awaddr == tsp_pkg::OFS_CTRL) begin
            nxt_state.ctrl = CW'(merge_strb(32'(q.ctrl), q.wdata, q.wstrb));
         end else if (q.awaddr == tsp_pkg::OFS_DATA) begin
            nxt_state.xfer_tx = WIDTH'(merge_strb(32'(q.xfer_tx), q.wdata, q.wstrb));
            nxt_state.tx_pend = 1'b1;
         end else if (q.awaddr == tsp_pkg::OFS_COND) begin
            nxt_state.cond_val = WIDTH'(merge_strb(32'(q.cond_val), q.wdata, q.wstrb));
         end else if (q.awaddr == tsp_pkg::OFS_TIME) begin
            nxt_state.time_val   = TW'(merge_strb(32'(q.time_val), q.wdata, q.wstrb));
            nxt_state.time_armed = 1'b1; // RULE8
         end else if (q.awaddr == tsp_pkg::OFS_CLKDIV) begin
            nxt_state.clk_div = 30'(merge_strb(32'(q.clk_div), q.wdata, q.wstrb));
         end else if (q.awaddr == tsp_pkg::OFS_CLKSRC) begin
            nxt_state.clk_src = 5'(merge_strb(32'(q.clk_src), q.wdata, q.wstrb));
         end else if (q.awaddr == tsp_pkg::OFS_IRQSTAT) begin
            nxt_state.irq_stat = q.irq_stat & ~q.wdata[tsp_pkg::IRQ_W-1:0];
         end else if (q.awaddr == tsp_pkg::OFS_IRQMASK) begin
            nxt_state.irq_mask = q.wdata[tsp_pkg::IRQ_W-1:0];
         end else if (q.awaddr == tsp_pkg::OFS_COUNT || q.awaddr == tsp_pkg::OFS_TSTAMP ||
                      q.awaddr == tsp_pkg::OFS_STATUS) begin
            nxt_state.bresp = tsp_pkg::RESP_OKAY;
         end else begin
            nxt_state.bresp = tsp_pkg::RESP_SLVERR;
         end
      end else if (q.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // Hardware set wins over software clear
      nxt_state.irq_stat = nxt_state.irq_stat | ev_set;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff         <= '0;
         state_ff.ctrl    <= tsp_pkg::CTRL_RST; // RULE16
         state_ff.clk_div <= tsp_pkg::CLKDIV_RST;
         state_ff.clk_src <= tsp_pkg::CLKSRC_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_OPEN_COLL_LOW: assert property (@(posedge clk) disable iff (rst) // RULE5
      open_coll |-> (pin_out == '0) && (pin_oe == (pin_oe & ~state_ff.pin_val)))
      else $error("open collector drove a one");
   AST_LINK_RELEASE: assert property (@(posedge clk) disable iff (rst) // RULE10
      link_en |-> (pin_oe == '0))
      else $error("port drove a pin owned by the link");
   AST_NARROW_WINS: assert property (@(posedge clk) disable iff (rst) // RULE11
      (pin_oe & pin_taken) == '0)
      else $error("port drove a pin taken by a narrower port");
   AST_INPUT_NO_DRIVE: assert property (@(posedge clk) disable iff (rst) // RULE2
      !dir_out |-> (pin_oe == '0))
      else $error("input port drove its pins");
   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst) // RULE17
      port_tick |=> (state_ff.cnt == TW'($past(state_ff.cnt) + 1'b1)))
      else $error("port counter did not step on tick");
   AST_OUT_STAMP: assert property (@(posedge clk) disable iff (rst) // RULE9
      (dir_out && port_tick && state_ff.tx_pend && time_ok && !state_ff.shifting
       && !state_ff.ctrl[tsp_pkg::CB_SERIAL])
      |=> (state_ff.tstamp == $past(state_ff.cnt)) && (state_ff.pin_val == $past(state_ff.xfer_tx)))
      else $error("output transfer lost its timestamp or data");
   AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst) // RULE4
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read answer not given next cycle");
   AST_READ_HOLD: assert property (@(posedge clk) disable iff (rst) // RULE4
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed before it was taken");
   AST_RESET_BLOCK0: assert property (@(posedge clk) // RULE16
      $past(rst) |-> (state_ff.ctrl[tsp_pkg::CB_SEL_HI:tsp_pkg::CB_SEL_LO] == 3'h0))
      else $error("port not on clock block 0 after reset");
   AST_EVENT_FLAG: assert property (@(posedge clk) disable iff (rst) // RULE18
      port_event |-> state_ff.irq_stat[tsp_pkg::IB_COND] && state_ff.rx_valid)
      else $error("core event without completed conditional input");
endmodule

// File: tb/tsp_pins_model.sv
/*
 Far-side pin hardware of the timed serdes port: resolves each pin and makes the
 1-bit application clock. Assumes the port's clk; the bench sets far-side levels.
*/
module tsp_pins_model #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] pin_out,
   input  wire logic [WIDTH-1:0] pin_oe,
   input  wire logic [WIDTH-1:0] far_val,
   input  wire logic             clk_run,
   output logic [WIDTH-1:0]      pin_in,
   output logic                  ext_clk_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_ff = 2'h0;
   // Released pins show the far side's level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & far_val);
   // Application clock stands still unless enabled
   always @(posedge clk) begin
      if (clk_run) div_ff <= div_ff + 2'h1;
   end
   assign ext_clk_in = div_ff[1];
endmodule

// File: tb/timed_serdes_io_port_bench.sv
/*
 Self-checking bench of the timed serdes port: AXI4-Lite tasks, output, input,
 timing, interrupt and clock-block scenarios. Assumes tsp_pkg and tsp_port.
*/
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module timed_serdes_io_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W = 8;
   logic        clk = 1'h0, rst = 1'h1, clk_run = 1'h0, strb = 1'h1, link = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, ob, ev, irq, ext_clk;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h5e1e, d, v, c;
   logic [1:0]  bresp, rresp;
   logic [W-1:0] pin_in, pin_out, pin_oe, far = 8'h00, taken = 8'h00;
   int          fail_count = 0, checks = 0, ob_n = 0, ev_n = 0, b;

   tsp_port #(.WIDTH(W)) tsp_port_i (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_taken(taken), .link_en(link),
      .ext_clk_in(ext_clk), .inbound_strobe(strb), .outbound_strobe(ob), .port_event(ev),
      .irq(irq));
   tsp_pins_model #(.WIDTH(W)) tsp_pins_model_i (.clk(clk), .pin_out(pin_out),
      .pin_oe(pin_oe), .far_val(far), .clk_run(clk_run), .pin_in(pin_in), .ext_clk_in(ext_clk));

   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (ob === 1'h1) ob_n++;
      if (ev === 1'h1) ev_n++;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [W-1:0] exp_oe(logic oc, logic [W-1:0] dv, logic [W-1:0] tk, logic lk);
      return lk ? 8'h00 : ((oc ? ~dv : 8'hff) & ~tk);
   endfunction

   task results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task tmo(input int n);
      if (n >= 60) begin
         fail_count++;
         $display("MISMATCH %0t wait ran out", $time);
         results();
      end
   endtask
   task tdone(input string s);
      $display("test %s done", s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      int n;
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 60; n++) begin
         @(posedge clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      bready <= 1'h0;
      tmo(n);
      `CHK(bresp, er)
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, input logic [1:0] er);
      int n;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 60; n++) begin
         @(posedge clk);
         if (arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      dat = rdata;
      rready <= 1'h0;
      tmo(n);
      `CHK(rresp, er)
      @(posedge clk);
   endtask
   task automatic wait_for(ref int cnt, input int base);
      int n;
      for (n = 0; n < 60; n++) begin
         @(posedge clk);
         if (cnt > base) break;
      end
      tmo(n);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      `CHK(pin_oe, 8'h00)
      rd(tsp_pkg::OFS_CTRL, d, tsp_pkg::RESP_OKAY);
      `CHK(d, 32'h0000_0000)
      rd(tsp_pkg::OFS_COUNT, c, tsp_pkg::RESP_OKAY);
      rd(tsp_pkg::OFS_COUNT, d, tsp_pkg::RESP_OKAY);
      `CHK(d[15:0] - c[15:0], 16'h0003)
      rd(8'h3C, d, tsp_pkg::RESP_SLVERR);
      `CHK(d, 32'h0000_0000)
      wr(8'h3C, rnd(), tsp_pkg::RESP_SLVERR);
      tdone("reset and map");
      // ------------------------------------------------------------
      // Output: push-pull, open collector, narrower port, link
      // ------------------------------------------------------------
      for (int k = 0; k < 4; k++) begin
         d = rnd();
         taken <= (k == 2) ? d[15:8] : 8'h00;
         link <= (k == 3);
         wr(tsp_pkg::OFS_CTRL, 32'h0000_0403 | {29'h0, k[0], 2'h0}, tsp_pkg::RESP_OKAY);
         b = ob_n;
         wr(tsp_pkg::OFS_DATA, d, tsp_pkg::RESP_OKAY);
         wait_for(ob_n, b);
         `CHK(pin_oe, exp_oe(k[0], d[W-1:0], taken, link))
         `CHK(pin_out & pin_oe, (k[0] ? 8'h00 : d[W-1:0]) & pin_oe)
      end
      taken <= 8'h00;
      link <= 1'h0;
      rd(tsp_pkg::OFS_IRQSTAT, d, tsp_pkg::RESP_OKAY);
      `CHK(d[0], 1'h1)
      `CHK(irq, 1'h0)
      wr(tsp_pkg::OFS_IRQMASK, 32'h0000_0001, tsp_pkg::RESP_OKAY);
      `CHK(irq, 1'h1)
      wr(tsp_pkg::OFS_IRQSTAT, 32'h0000_0003, tsp_pkg::RESP_OKAY);
      `CHK(irq, 1'h0)
      tdone("output");
      rd(tsp_pkg::OFS_COUNT, c, tsp_pkg::RESP_OKAY);
      v = c + 32'h0000_0028;
      wr(tsp_pkg::OFS_TIME, v, tsp_pkg::RESP_OKAY);
      b = ob_n;
      wr(tsp_pkg::OFS_DATA, rnd(), tsp_pkg::RESP_OKAY);
      wait_for(ob_n, b);
      rd(tsp_pkg::OFS_TSTAMP, d, tsp_pkg::RESP_OKAY);
      `CHK(d[15:0], v[15:0])
      tdone("timed");
      // ------------------------------------------------------------
      // Conditional input gated by the inbound strobe
      // ------------------------------------------------------------
      v = rnd();
      far <= v[W-1:0];
      strb <= 1'h0;
      wr(tsp_pkg::OFS_COND, {24'h0, v[W-1:0]}, tsp_pkg::RESP_OKAY);
      wr(tsp_pkg::OFS_CTRL, 32'h0000_0209, tsp_pkg::RESP_OKAY);
      b = ev_n;
      repeat (8) @(posedge clk);
      `CHK(ev_n, b)
      strb <= 1'h1;
      wait_for(ev_n, b);
      rd(tsp_pkg::OFS_DATA, d, tsp_pkg::RESP_OKAY);
      `CHK(d[W-1:0], v[W-1:0])
      rd(tsp_pkg::OFS_IRQSTAT, d, tsp_pkg::RESP_OKAY);
      `CHK(d[1], 1'h1)
      tdone("input");
      wr(tsp_pkg::OFS_CTRL, 32'h0000_0019, tsp_pkg::RESP_OKAY);
      b = ev_n;
      repeat (8) @(posedge clk);
      `CHK(ev_n, b)
      far <= ~v[W-1:0];
      wait_for(ev_n, b);
      tdone("not equal");
      wr(tsp_pkg::OFS_CLKSRC, 32'h0000_0001, tsp_pkg::RESP_OKAY);
      wr(tsp_pkg::OFS_CTRL, 32'h0000_0041, tsp_pkg::RESP_OKAY);
      rd(tsp_pkg::OFS_COUNT, c, tsp_pkg::RESP_OKAY);
      rd(tsp_pkg::OFS_COUNT, d, tsp_pkg::RESP_OKAY);
      `CHK(d, c)
      clk_run <= 1'h1;
      rd(tsp_pkg::OFS_COUNT, c, tsp_pkg::RESP_OKAY);
      repeat (40) @(posedge clk);
      rd(tsp_pkg::OFS_COUNT, d, tsp_pkg::RESP_OKAY);
      `CHK((d[15:0] - c[15:0]) inside {16'h000a, 16'h000b}, 1'h1)
      tdone("clock block");
      wr(tsp_pkg::OFS_CTRL, 32'h0000_0423, tsp_pkg::RESP_OKAY);
      d = rnd();
      b = ob_n;
      wr(tsp_pkg::OFS_DATA, d, tsp_pkg::RESP_OKAY);
      repeat (W + 4) @(posedge clk);
      `CHK(ob_n - b, W)
      `CHK(pin_out[0], d[W-1])
      tdone("serial");
      results();
   end
endmodule
